// file: logic/odt_pkg.sv
// package for the termination control pair: mode register fields, timing, states
// assumes a single 100 MHz clock shared by controller and device ends
package odt_pkg;

    // clock rate
    localparam int CLK_MHZ = 100;

    // mode register indices and field positions
    localparam logic [2:0] MR1_IDX  = 3'h1;
    localparam logic [2:0] MR2_IDX  = 3'h2;
    localparam logic [2:0] MR5_IDX  = 3'h5;
    localparam int MR1_DLL_BIT      = 0;
    localparam int MR1_NOM_LSB      = 8;
    localparam int MR2_WR_LSB       = 9;
    localparam int MR5_BUFDIS_BIT   = 5;
    localparam int MR5_PARK_LSB     = 6;
    localparam logic [2:0] RTT_OFF  = 3'h0;

    // reset values of the device mode fields
    localparam logic       DLL_EN_RST = 1'h0;
    localparam logic       BUFDIS_RST = 1'h0;
    localparam logic [2:0] RTT_RST    = 3'h0;

    // termination selection presented by the device
    localparam logic [1:0] SEL_PARK = 2'h0;
    localparam logic [1:0] SEL_NOM  = 2'h1;

    // asynchronous turn-on / turn-off times, longest figure, rounded down but never below one cycle
    localparam int T_AONAS_NS = 9;
    localparam int T_AOFAS_NS = 9;
    localparam int AONAS_CYC_RAW = (T_AONAS_NS * CLK_MHZ) / 1000;
    localparam int AOFAS_CYC_RAW = (T_AOFAS_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] AONAS_CYC = (AONAS_CYC_RAW < 1) ? 8'h01 : 8'(AONAS_CYC_RAW);
    localparam logic [7:0] AOFAS_CYC = (AOFAS_CYC_RAW < 1) ? 8'h01 : 8'(AOFAS_CYC_RAW);

    // latency used while the dll runs (synchronous mode lies outside this block)
    localparam logic [7:0] SYNC_LAT_CYC = 8'h07;
    // write latency, used for the power-down entry uncertainty window
    localparam logic [7:0] WL_CYC       = 8'h09;
    localparam logic [7:0] ANPD_CYC     = WL_CYC - 8'h01;

    // power-down entry and exit spacing
    localparam logic [7:0] DODTOFF_CYC  = 8'h07;
    localparam logic [7:0] PRE_CYC      = DODTOFF_CYC + 8'h01;
    localparam logic [7:0] CPDED_CYC    = 8'h04;
    localparam int T_XP_NS = 24;
    localparam logic [7:0] XP_CYC = 8'((T_XP_NS * CLK_MHZ + 999) / 1000);

    // average refresh interval: 7800 ns normal, 3900 ns when hot
    localparam int T_REFI_NS     = 7800;
    localparam int T_REFI_HOT_NS = 3900;
    localparam logic [15:0] REFI_CYC     = 16'((T_REFI_NS * CLK_MHZ) / 1000);
    localparam logic [15:0] REFI_HOT_CYC = 16'((T_REFI_HOT_NS * CLK_MHZ) / 1000);

    // controller register map (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_MRS    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_REFCNT = 4'hc;
    localparam int CTRL_PD_BIT   = 0;
    localparam int CTRL_ODT_BIT  = 1;
    localparam int CTRL_HOT_BIT  = 2;
    localparam int MRS_IDX_LSB   = 14;

    // controller power-down sequence
    typedef enum logic [2:0] {
        ODT_ST_ACT,
        ODT_ST_PRE,
        ODT_ST_ENT,
        ODT_ST_FLT,
        ODT_ST_EXIT
    } odt_st_t;

endpackage : odt_pkg

// file: logic/odt_if.sv
// link between controller and device: cke, odt pin, mode register writes
// assumes both ends run on the same clock; the odt wire is resolved here
`timescale 1ns/1ps
interface odt_if;
    logic        cke;
    logic        odt_out;
    logic        odt_oe;
    wire         odt_pin;
    logic        mrs_we;
    logic [2:0]  mrs_idx;
    logic [13:0] mrs_addr;

    // released odt shows the inverse of the last level; the device must not rely on it
    assign odt_pin = odt_oe ? odt_out : ~odt_out;

    modport ctl (output cke, output odt_out, output odt_oe,
                 output mrs_we, output mrs_idx, output mrs_addr);
    modport dev (input cke, input odt_pin, input mrs_we, input mrs_idx, input mrs_addr);
endinterface : odt_if

// file: logic/odt_dly.sv
// loadable down counter giving a one-cycle done pulse after the loaded count
// assumes load value of at least one; a new load restarts the count
`timescale 1ns/1ps
module odt_dly (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       load_i,
    input  wire logic [7:0] val_i,
    output logic            busy_o,
    output logic            done_o
);
    logic [7:0] cnt_r;

    // count down; done pulses on the edge the count reaches zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 8'h00;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (load_i) begin
                cnt_r <= val_i;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign busy_o = (cnt_r != 8'h00);
endmodule : odt_dly

// file: logic/odt_dev.sv
// device end: selects park or nominal termination from the odt pin and mode bits
// assumes cke, odt and mode writes come from logic on the same clock
//
// Notes on behaviour
// RQ1: dll off selects asynchronous termination mode
// RQ2: async request skips additive and fixed latency
// RQ3: start toward nominal within turn-on window
// RQ4: start leaving nominal within turn-off window
// RQ5: buffer-off power-down never applies nominal
// RQ6: controller holds odt steady around cke fall
// RQ7: controller may float odt after entry delay
// RQ8: odt near power-down entry: either value
// RQ9: controller drives odt low through exit
// RQ10: hot operation halves the refresh interval
// RQ11: odt low presents park termination
// RQ12: write termination disabled with dll off
// RQ13: odt sampled each edge while cke high
`timescale 1ns/1ps
module odt_dev
    import odt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    odt_if.dev              lnk,
    output logic [1:0]      rtt_sel_o,
    output logic [2:0]      rtt_code_o,
    output logic            async_mode_o,
    output logic            pd_o,
    output logic            change_o,
    output logic            dyn_err_o
);

    ////////////////////////////////////////////////////////////////////////////
    // mode register fields

    logic       dll_en_r;
    logic       bufdis_r;
    logic [2:0] nom_r;
    logic [2:0] wr_r;
    logic [2:0] park_r;

    // mode register writes arrive as one-cycle strobes from the controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dll_en_r <= DLL_EN_RST;
            bufdis_r <= BUFDIS_RST;
            nom_r    <= RTT_RST;
            wr_r     <= RTT_RST;
            park_r   <= RTT_RST;
        end else if (ce_i && lnk.mrs_we) begin
            case (lnk.mrs_idx)
                MR1_IDX: begin
                    dll_en_r <= lnk.mrs_addr[MR1_DLL_BIT];
                    nom_r    <= lnk.mrs_addr[MR1_NOM_LSB +: 3];
                end
                MR2_IDX: begin
                    wr_r <= lnk.mrs_addr[MR2_WR_LSB +: 3];
                end
                MR5_IDX: begin
                    bufdis_r <= lnk.mrs_addr[MR5_BUFDIS_BIT];
                    park_r   <= lnk.mrs_addr[MR5_PARK_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
    end

    // asynchronous mode follows the dll enable bit directly
    logic async_mode;
    assign async_mode = !dll_en_r; // RQ1

    ////////////////////////////////////////////////////////////////////////////
    // cke and odt sampling

    logic cke_r;
    logic odt_smp_r;
    logic odt_in;

    // a floating pin reads as low here rather than spreading unknowns
    assign odt_in = (lnk.odt_pin === 1'b1);

    // cke is registered each edge; power-down starts the edge it is seen low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cke_r <= 1'b0;
        end else if (ce_i) begin
            cke_r <= lnk.cke;
        end
    end

    // odt is only sampled while cke is high; in power-down the last value holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odt_smp_r <= 1'b0;
        end else if (ce_i && lnk.cke) begin
            odt_smp_r <= odt_in; // RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // termination request

    logic pd;
    logic req_nom;

    assign pd = !cke_r;

    // with the buffer switched off, power-down forces park; without it the
    // held sample keeps steering termination. a sample taken in the last
    // cycles before entry may therefore land either way, and nothing here
    // tries to resolve which one wins
    assign req_nom = odt_smp_r && !(bufdis_r && pd); // RQ5 RQ8

    ////////////////////////////////////////////////////////////////////////////
    // transition timing

    logic       applied_r;
    logic       pend_r;
    logic       pend_val_r;
    logic       load;
    logic [7:0] load_val;
    logic       dly_busy;
    logic       dly_done;

    // a new request or a reversal of the pending one restarts the timer
    assign load = ((req_nom != applied_r) && !pend_r)
               || (pend_r && (req_nom != pend_val_r));

    // async mode uses the turn-on/turn-off windows with no added latency;
    // the dll-on latency stands in for synchronous mode, covered elsewhere
    always_comb begin
        if (async_mode) begin
            load_val = req_nom ? AONAS_CYC : AOFAS_CYC; // RQ2 RQ3 RQ4
        end else begin
            load_val = SYNC_LAT_CYC;
        end
    end

    odt_dly u_dly (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .load_i (load),
        .val_i  (load_val),
        .busy_o (dly_busy),
        .done_o (dly_done)
    );

    // track the pending target; a request that returns to the applied value while the
    // timer runs stays pending on that value until the restarted window expires
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r     <= 1'b0;
            pend_val_r <= 1'b0;
        end else if (ce_i) begin
            if (load) begin
                pend_r     <= (req_nom != applied_r) || dly_busy;
                pend_val_r <= req_nom;
            end else if (dly_done) begin
                pend_r <= 1'b0;
            end
        end
    end

    // applied termination switches when the window expires
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            applied_r <= 1'b0;
        end else if (ce_i && pend_r && dly_done && !load) begin
            applied_r <= pend_val_r; // RQ3 RQ4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // park is shown whenever nominal is not applied; no write termination
    // exists in this block so park covers every odt-low case
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtt_sel_o  <= SEL_PARK;
            rtt_code_o <= RTT_RST;
        end else if (ce_i) begin
            rtt_sel_o  <= applied_r ? SEL_NOM : SEL_PARK; // RQ11
            rtt_code_o <= applied_r ? nom_r : park_r;     // RQ11
        end
    end

    // status: mode, power-down, change pulse, illegal write termination
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            async_mode_o <= 1'b0;
            pd_o         <= 1'b0;
            change_o     <= 1'b0;
            dyn_err_o    <= 1'b0;
        end else if (ce_i) begin
            async_mode_o <= async_mode;
            pd_o         <= pd;
            change_o     <= pend_r && dly_done && !load && (pend_val_r != applied_r);
            // dynamic switching cannot run with the dll off; flag a nonzero field
            dyn_err_o    <= async_mode && (wr_r != RTT_OFF); // RQ12
        end
    end

endmodule : odt_dev

// file: logic/odt_ctl.sv
// controller end: wishbone registers, power-down odt sequencing, refresh pacing
// assumes a classic wishbone master on the same clock and the device on lnk
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module odt_ctl
    import odt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             ref_o,
    odt_if.ctl               lnk
);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave

    logic [2:0]  ctrl_r;
    logic [16:0] mrs_r;
    logic        mrs_go_r;
    logic        dll_en_r;
    logic        bufdis_r;
    logic [15:0] refcnt_r;
    odt_st_t     st_r;
    logic        wr_hit;
    logic [31:0] mask;
    logic [31:0] mrs_new;

    assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    assign mrs_new = ({15'h0000, mrs_r} & ~mask) | (wb_dat_i & mask);

    // ack one cycle after the request, dropped the next; writes land with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            case (wb_adr_i)
                REG_CTRL:   wb_dat_o <= {29'h00000000, ctrl_r};
                REG_MRS:    wb_dat_o <= {15'h0000, mrs_r};
                REG_STATUS: wb_dat_o <= {27'h0000000, lnk.odt_oe, lnk.cke, st_r};
                REG_REFCNT: wb_dat_o <= {16'h0000, refcnt_r};
                default:    wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // control bits and mode register command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= 3'h0;
            mrs_r    <= 17'h00000;
            mrs_go_r <= 1'b0;
        end else if (ce_i) begin
            mrs_go_r <= 1'b0;
            if (wr_hit && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
                ctrl_r <= wb_dat_i[2:0];
            end
            if (wr_hit && wb_adr_i == REG_MRS) begin
                mrs_r    <= mrs_new[16:0];
                mrs_go_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode register issue, with a shadow of the bits this end depends on

    logic [13:0] mrs_addr_fix;
    logic [2:0]  mrs_idx;

    assign mrs_idx = mrs_r[MRS_IDX_LSB +: 3];

    // with the dll off, write termination is forced to zero before issue
    always_comb begin
        mrs_addr_fix = mrs_r[13:0];
        if (mrs_idx == MR2_IDX && !dll_en_r) begin
            mrs_addr_fix[MR2_WR_LSB +: 3] = RTT_OFF; // RQ12
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lnk.mrs_we   <= 1'b0;
            lnk.mrs_idx  <= 3'h0;
            lnk.mrs_addr <= 14'h0000;
            dll_en_r     <= DLL_EN_RST;
            bufdis_r     <= BUFDIS_RST;
        end else if (ce_i) begin
            lnk.mrs_we <= mrs_go_r;
            if (mrs_go_r) begin
                lnk.mrs_idx  <= mrs_idx;
                lnk.mrs_addr <= mrs_addr_fix;
                if (mrs_idx == MR1_IDX) begin
                    dll_en_r <= mrs_r[MR1_DLL_BIT];
                end
                if (mrs_idx == MR5_IDX) begin
                    bufdis_r <= mrs_r[MR5_BUFDIS_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-down sequencing

    logic       dly_load;
    logic [7:0] dly_val;
    logic       dly_done;

    odt_dly u_dly (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .load_i (dly_load),
        .val_i  (dly_val),
        .busy_o (),
        .done_o (dly_done)
    );

    // odt is frozen from entry request until the entry delay runs out; the
    // float only happens when the device has its buffer switched off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= ODT_ST_ACT;
            lnk.cke     <= 1'b1;
            lnk.odt_out <= 1'b0;
            lnk.odt_oe  <= 1'b1;
            dly_load    <= 1'b0;
            dly_val     <= 8'h00;
        end else if (ce_i) begin
            dly_load <= 1'b0;
            case (st_r)
                ODT_ST_ACT: begin
                    lnk.odt_out <= ctrl_r[CTRL_ODT_BIT];
                    if (ctrl_r[CTRL_PD_BIT] && !dly_load) begin
                        st_r     <= ODT_ST_PRE;
                        dly_load <= 1'b1;
                        dly_val  <= PRE_CYC; // RQ6
                    end
                end
                ODT_ST_PRE: begin
                    if (dly_done) begin
                        lnk.cke  <= 1'b0;
                        st_r     <= ODT_ST_ENT;
                        dly_load <= 1'b1;
                        dly_val  <= CPDED_CYC; // RQ6
                    end
                end
                ODT_ST_ENT: begin
                    if (dly_done) begin
                        lnk.odt_oe <= !bufdis_r; // RQ7
                        st_r       <= ODT_ST_FLT;
                    end
                end
                ODT_ST_FLT: begin
                    if (!ctrl_r[CTRL_PD_BIT]) begin
                        lnk.cke     <= 1'b1;
                        lnk.odt_out <= 1'b0; // RQ9
                        lnk.odt_oe  <= 1'b1; // RQ9
                        st_r        <= ODT_ST_EXIT;
                        dly_load    <= 1'b1;
                        dly_val     <= XP_CYC;
                    end
                end
                ODT_ST_EXIT: begin
                    if (dly_done) begin
                        st_r <= ODT_ST_ACT;
                    end
                end
                default: begin
                    st_r <= ODT_ST_ACT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // refresh pacing: the hot bit halves the interval

    logic [15:0] ref_tmr_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_tmr_r <= 16'h0000;
            ref_o     <= 1'b0;
            refcnt_r  <= 16'h0000;
        end else if (ce_i) begin
            ref_o <= 1'b0;
            if (ref_tmr_r >= (ctrl_r[CTRL_HOT_BIT] ? REFI_HOT_CYC : REFI_CYC) - 16'h0001) begin
                ref_tmr_r <= 16'h0000; // RQ10
                ref_o     <= 1'b1;
                refcnt_r  <= refcnt_r + 16'h0001;
            end else begin
                ref_tmr_r <= ref_tmr_r + 16'h0001;
            end
        end
    end

endmodule : odt_ctl

// file: tb/odt_asserts.sv
// checker for the link between controller and device ends, plus applied termination
// assumes one clock, synchronous active-high reset, instantiated beside the interface
`timescale 1ns/1ps
module odt_asserts
    import odt_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cke,
    input wire logic        odt_out,
    input wire logic        odt_oe,
    input wire logic        mrs_we,
    input wire logic [2:0]  mrs_idx,
    input wire logic [13:0] mrs_addr,
    input wire logic [1:0]  rtt_sel_o,
    input wire logic        async_mode_o,
    input wire logic        pd_o,
    input wire logic        change_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // cycles the odt level has stood still; saturates so a long hold never wraps
    logic [3:0] hold_r;
    logic       odt_q_r;
    always_ff @(posedge clk_i) begin
        odt_q_r <= odt_out;
        if (rst_i || odt_out != odt_q_r) hold_r <= 4'h0;
        else if (hold_r != 4'hf) hold_r <= hold_r + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_dll_on;
        mrs_we && mrs_idx == MR1_IDX && mrs_addr[MR1_DLL_BIT] |-> ##2 !async_mode_o;
    endproperty
    a_dll_on: assert property (p_dll_on)
        else $error("dll enable left async mode on");
    property p_aon;
        (async_mode_o && cke && !pd_o && odt_oe && odt_out) [*5] |=> rtt_sel_o == SEL_NOM;
    endproperty
    a_aon: assert property (p_aon)
        else $error("nominal not reached after odt high");
    property p_aof;
        (async_mode_o && cke && !pd_o && odt_oe && !odt_out) [*5] |=> rtt_sel_o == SEL_PARK;
    endproperty
    a_aof: assert property (p_aof)
        else $error("park not reached after odt low");
    property p_chg;
        change_o |=> rtt_sel_o != $past(rtt_sel_o);
    endproperty
    a_chg: assert property (p_chg)
        else $error("change pulse without a termination change");
    property p_flt_park;
        !odt_oe [*2] |-> rtt_sel_o == SEL_PARK;
    endproperty
    a_flt_park: assert property (p_flt_park)
        else $error("nominal applied while odt floats");
    property p_pre_hold;
        $fell(cke) |-> odt_oe && hold_r >= 4'h7;
    endproperty
    a_pre_hold: assert property (p_pre_hold)
        else $error("odt moved before cke fell");
    property p_ent_hold;
        $fell(cke) |-> (odt_oe && $stable(odt_out)) [*4];
    endproperty
    a_ent_hold: assert property (p_ent_hold)
        else $error("odt moved right after cke fell");
    property p_float;
        $fell(odt_oe) |-> !cke && !$past(cke, 4);
    endproperty
    a_float: assert property (p_float)
        else $error("odt released too early");
    property p_exit;
        $rose(cke) |-> (odt_oe && !odt_out) [*3];
    endproperty
    a_exit: assert property (p_exit)
        else $error("odt not held low through exit");
    property p_wr_off;
        mrs_we && mrs_idx == MR2_IDX && async_mode_o |-> mrs_addr[MR2_WR_LSB +: 3] == RTT_OFF;
    endproperty
    a_wr_off: assert property (p_wr_off)
        else $error("write termination set with dll off");
    property p_pd;
        $fell(cke) |-> ##[1:2] pd_o;
    endproperty
    a_pd: assert property (p_pd)
        else $error("power-down not seen after cke fell");
endmodule : odt_asserts

// file: tb/odt_async_and_powerdown_control_bench.sv
// testbench: wishbone master drives the controller, which faces the device end
// assumes package and interface compiled first; one 100 MHz clock
`timescale 1ns/1ps
module odt_async_and_powerdown_control_bench
    import odt_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  adr   = 4'h0;
    logic [31:0] dat   = 32'h0;
    logic [31:0] rdat;
    logic        ack, ref_p, async_m, pd, chg, derr;
    logic [1:0]  rtt_sel;
    logic [2:0]  rtt_code;
    logic [15:0] nref  = 16'h0;
    int          fail_count = 0;
    int          n_checks   = 0;
    odt_if       lnk ();

    ////////////////////////////////////////////////////////////////////////////////
    // cyc and stb share one signal: classic single cycles only
    odt_ctl u_odt_ctl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ref_o(ref_p), .lnk(lnk));
    odt_dev u_odt_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(lnk),
        .rtt_sel_o(rtt_sel), .rtt_code_o(rtt_code), .async_mode_o(async_m), .pd_o(pd),
        .change_o(chg), .dyn_err_o(derr));
    odt_asserts u_odt_asserts (.clk_i(clk_i), .rst_i(rst_i), .cke(lnk.cke),
        .odt_out(lnk.odt_out), .odt_oe(lnk.odt_oe), .mrs_we(lnk.mrs_we),
        .mrs_idx(lnk.mrs_idx), .mrs_addr(lnk.mrs_addr), .rtt_sel_o(rtt_sel),
        .async_mode_o(async_m), .pd_o(pd), .change_o(chg));

    // clock and refresh pulse tally
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (rst_i) nref <= 16'h0;
        else if (ref_p === 1'b1) nref <= nref + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task conclude();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; request held until the edge that samples ack
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        q = rdat;
        cyc <= 1'b0;
        if (i == 20) begin
            fail_count++;
            $display("[ERR] %0t bus timeout", $time);
            conclude();
        end
    endtask : wb
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    // mode write lands on the device two cycles after the edge that samples the ack
    task mrs(input logic [2:0] i, input logic [13:0] d);
        wr(REG_MRS, {15'h0, i, d});
        repeat (5) @(posedge clk_i);
    endtask : mrs
    task ws(input logic [1:0] e, input int n);
        int i;
        for (i = 0; i < n && rtt_sel !== e; i++) @(posedge clk_i);
        chk({30'h0, rtt_sel}, {30'h0, e});
    endtask : ws
    task poll(input logic [31:0] e);
        logic [31:0] q;
        int          i;
        for (i = 0; i < 20; i++) begin
            wb(1'b0, REG_STATUS, 32'h0, q);
            if (q === e) break;
        end
        chk(q, e);
    endtask : poll
    task meas(input logic [15:0] e);
        int i;
        for (i = 0; i < 2000 && ref_p !== 1'b1; i++) @(posedge clk_i);
        for (i = 1; i < 2000; i++) begin
            @(posedge clk_i);
            if (ref_p === 1'b1) break;
        end
        chk(32'(i), {16'h0, e});
    endtask : meas

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset();
        rd(REG_STATUS, 32'h18);
        wr(4'h2, 32'hffffffff);
        rd(4'h2, 32'h0);
        chk({31'h0, async_m}, 32'h1);
        chk({30'h0, rtt_sel}, {30'h0, SEL_PARK});
    endtask : t_reset
    task t_async();
        mrs(MR5_IDX, 14'h0c0);
        mrs(MR1_IDX, 14'h500);
        chk({29'h0, rtt_code}, 32'h3);
        wr(REG_CTRL, 32'h2);
        ws(SEL_NOM, 8);
        chk({29'h0, rtt_code}, 32'h5);
        wr(REG_CTRL, 32'h0);
        ws(SEL_PARK, 8);
    endtask : t_async
    task t_dll();
        mrs(MR1_IDX, 14'h501);
        chk({31'h0, async_m}, 32'h0);
        wr(REG_CTRL, 32'h2);
        repeat (4) @(posedge clk_i);
        chk({30'h0, rtt_sel}, {30'h0, SEL_PARK});
        ws(SEL_NOM, 14);
        wr(REG_CTRL, 32'h0);
        ws(SEL_PARK, 14);
        mrs(MR1_IDX, 14'h500);
        mrs(MR2_IDX, 14'h600);
        chk({31'h0, derr}, 32'h0);
    endtask : t_dll
    // odt requested high through entry and exit: exit must still hold it low
    task t_pd();
        mrs(MR5_IDX, 14'h0e0);
        wr(REG_CTRL, 32'h2);
        ws(SEL_NOM, 8);
        wr(REG_CTRL, 32'h3);
        poll(32'h3);
        chk({30'h0, rtt_sel}, {30'h0, SEL_PARK});
        chk({31'h0, pd}, 32'h1);
        wr(REG_CTRL, 32'h2);
        poll(32'h18);
        ws(SEL_NOM, 6);
        wr(REG_CTRL, 32'h0);
    endtask : t_pd
    task t_ref();
        meas(REFI_CYC);
        wr(REG_CTRL, 32'h4);
        meas(REFI_HOT_CYC);
        @(posedge clk_i); // let the tally take the last pulse
        rd(REG_REFCNT, {16'h0, nref});
        wr(REG_CTRL, 32'h0);
    endtask : t_ref

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_async();
        t_dll();
        t_pd();
        t_ref();
        conclude();
    end
endmodule : odt_async_and_powerdown_control_bench
